/* File: design/arm_digit_mod.sv */
// one-position address modifier: adds or subtracts one with carry or borrow
`timescale 1ns/100ps
module arm_digit_mod (
	arm_mod_if.mdf m
);
	logic [3:0] d;
	logic       borrow;
	logic       carry;

	always_comb
	begin
		d = arm_pkg::dec25(m.digit_in);
		// borrow and carry are seen on the latch pairs themselves
		borrow = (m.mode_in == arm_pkg::MOD_MINUS) && m.digit_in[arm_pkg::B2]
			&& m.digit_in[arm_pkg::B8];
		carry = (m.mode_in == arm_pkg::MOD_PLUS) && m.digit_in[arm_pkg::B1]
			&& m.digit_in[arm_pkg::B8];
		m.digit_out = m.digit_in;
		m.mode_out = arm_pkg::MOD_ZERO;
		case (m.mode_in)
			arm_pkg::MOD_MINUS:
			begin
				if (borrow)
				begin
					m.digit_out = arm_pkg::C9;
					m.mode_out = arm_pkg::MOD_MINUS;
				end
				else
					m.digit_out = arm_pkg::enc25(4'(d - 4'h1));
			end
			arm_pkg::MOD_PLUS:
			begin
				if (carry)
				begin
					m.digit_out = arm_pkg::C0;
					m.mode_out = arm_pkg::MOD_PLUS;
				end
				else
					m.digit_out = arm_pkg::enc25(4'(d + 4'h1));
			end
			default:
			begin
				m.digit_out = m.digit_in;
				m.mode_out = arm_pkg::MOD_ZERO;
			end
		endcase
	end
endmodule : arm_digit_mod

/* File: design/arm_mod_if.sv */
// carrier between the sequencer and the one-position modifier
`timescale 1ns/100ps
interface arm_mod_if;
	logic                [4:0] digit_in;
	arm_pkg::arm_mode_t        mode_in;
	logic                [4:0] digit_out;
	arm_pkg::arm_mode_t        mode_out;
	modport seq (output digit_in, output mode_in, input digit_out, input mode_out);
	modport mdf (input digit_in, input mode_in, output digit_out, output mode_out);
endinterface : arm_mod_if

/* File: design/arm_pkg.sv */
// constants, codes and types shared by the address register unit
package arm_pkg;
	// apb register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_SERIAL = 8'h04;
	localparam logic [7:0] OFS_STAR   = 8'h08;
	localparam logic [7:0] OFS_VIEW   = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// ctrl, serial and status register fields
	localparam int CTRL_SEL_LSB   = 0;
	localparam int CTRL_CYC_LSB   = 3;
	localparam int CTRL_SCAN_LSB  = 5;
	localparam int CTRL_START     = 8;
	localparam int CTRL_EXEC      = 9;
	localparam int CTRL_IFROMSTAR = 10;
	localparam int CTRL_PROGRST   = 11;
	localparam int CTRL_REGRST    = 12;
	localparam int SER_REG_LSB    = 8;
	localparam int STAT_POS_LSB   = 8;
	localparam int STAT_MODE_LSB  = 4;
	localparam int STAT_GATE_LSB  = 1;

	// address geometry: five positions of five latches
	localparam int NPOS    = 5;
	localparam int NBITS   = 5;
	localparam int NREGS   = 7;
	localparam int AWIDTH  = NPOS * NBITS;
	localparam logic [2:0] POS_UNITS = 3'h0;
	localparam logic [2:0] POS_TTH   = 3'h4;

	// working register indices
	localparam logic [2:0] R_I = 3'h0;
	localparam logic [2:0] R_A = 3'h1;
	localparam logic [2:0] R_B = 3'h2;
	localparam logic [2:0] R_C = 3'h3;
	localparam logic [2:0] R_D = 3'h4;
	localparam logic [2:0] R_E = 3'h5;
	localparam logic [2:0] R_F = 3'h6;

	// latch order {8,4,2,1,0}
	localparam int B0 = 0;
	localparam int B1 = 1;
	localparam int B2 = 2;
	localparam int B8 = 4;
	localparam logic [4:0] C_EMPTY = 5'h00;
	localparam logic [4:0] C0 = 5'h14;
	localparam logic [4:0] C1 = 5'h03;
	localparam logic [4:0] C2 = 5'h05;
	localparam logic [4:0] C3 = 5'h06;
	localparam logic [4:0] C4 = 5'h09;
	localparam logic [4:0] C5 = 5'h0a;
	localparam logic [4:0] C6 = 5'h0c;
	localparam logic [4:0] C7 = 5'h11;
	localparam logic [4:0] C8 = 5'h18;
	localparam logic [4:0] C9 = 5'h12;

	// storage cycle timing: six logic gates, two clock pulses each
	localparam int CLK_MHZ        = 50;
	localparam int CYCLE_NS       = 4500;
	localparam int NGATES         = 6;
	localparam int PULSE_NS       = CYCLE_NS / (NGATES * 2);
	localparam int PULSE_CYC_I    = (PULSE_NS * CLK_MHZ) / 1000;
	localparam int PULSE_CYC      = (PULSE_CYC_I < 1) ? 1 : PULSE_CYC_I;
	localparam logic [7:0] PULSE_LAST = 8'(PULSE_CYC - 1);

	typedef enum logic [1:0] {CYC_I, CYC_A, CYC_B} arm_cycle_t;
	typedef enum logic [1:0] {SCAN_NONE, SCAN_FIRST, SCAN_SECOND, SCAN_THIRD} arm_scan_t;
	typedef enum logic [1:0] {MOD_ZERO, MOD_MINUS, MOD_PLUS} arm_mode_t;
	typedef enum logic [2:0] {G_IDLE, G_A, G_B, G_C, G_D, G_E, G_F} arm_gate_t;

	function automatic logic [3:0] dec25(input logic [4:0] c);
		case (c)
			C1: dec25 = 4'h1;
			C2: dec25 = 4'h2;
			C3: dec25 = 4'h3;
			C4: dec25 = 4'h4;
			C5: dec25 = 4'h5;
			C6: dec25 = 4'h6;
			C7: dec25 = 4'h7;
			C8: dec25 = 4'h8;
			C9: dec25 = 4'h9;
			default: dec25 = 4'h0;
		endcase
	endfunction : dec25

	function automatic logic [4:0] enc25(input logic [3:0] d);
		case (d)
			4'h1: enc25 = C1;
			4'h2: enc25 = C2;
			4'h3: enc25 = C3;
			4'h4: enc25 = C4;
			4'h5: enc25 = C5;
			4'h6: enc25 = C6;
			4'h7: enc25 = C7;
			4'h8: enc25 = C8;
			4'h9: enc25 = C9;
			default: enc25 = C0;
		endcase
	endfunction : enc25

	function automatic logic [2:0] cyc_target(input arm_cycle_t t);
		case (t)
			CYC_A: cyc_target = R_A;
			CYC_B: cyc_target = R_B;
			default: cyc_target = R_I;
		endcase
	endfunction : cyc_target
endpackage : arm_pkg

/* File: design/arm_unit.sv */
// address register unit: working registers, storage address register, modifier sequencer
`timescale 1ns/100ps
// What this block does
// - each position holds one 2-of-5 digit
// - instruction fields load A and B registers
// - C copies A, D copies B
// - E and F hold overlap character addresses
// - register reset clears latches before load
// - latch sets on channel, position, register coincidence
// - serial load starts at ten-thousands position
// - instruction register loads parallel from storage address
// - readout gates all five positions onto bus
// - storage address loads from bus each cycle
// - only program reset or presetn clears storage address
// - storage address latches follow bus bits
// - forward scan subtracts one, reverse adds one
// - borrow from zero, carry from nine
// - modification completes within one storage cycle
// - A loads storage address gate A, resets gate B
// - units written gate B, tens gate C, onward
// - scan latches select direction or no change
// - first scan presets minus one before units
// - borrow keeps minus-one latch set
// - after units, modify by zero unless borrow/carry
// - cycle type picks target, reset, five positions
module arm_unit (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [24:0] storage_addr,
	output logic             cycle_busy
);
	localparam int AW = arm_pkg::AWIDTH;

	logic [AW-1:0]            regs_ff [arm_pkg::NREGS];
	logic [AW-1:0]            star_ff;
	logic [AW-1:0]            addr_bus;
	logic [2:0]               sel_ff;
	arm_pkg::arm_cycle_t      cyc_ff;
	arm_pkg::arm_scan_t       scan_ff;
	logic [2:0]               ser_pos_ff;
	arm_pkg::arm_gate_t       gate_ff;
	logic                     phase_ff;
	logic [7:0]               div_ff;
	logic [2:0]               mpos_ff;
	arm_pkg::arm_mode_t       mode_ff;
	logic [31:0]              prdata_ff;
	logic                     pslverr_ff;
	logic                     wr;
	logic                     rd;
	logic                     tick;
	logic                     p1;
	logic                     p2;
	logic [2:0]               tgt;
	logic [2:0]               ser_reg;
	logic [4:0]               ser_bits;
	logic                     ser_wr;
	logic                     ctrl_wr;
	logic                     start;
	logic                     mapped;
	logic [31:0]              rd_val;
	arm_pkg::arm_mode_t       preset_mode;
	arm_mod_if                mif ();

	function automatic logic [4:0] pos_get(input logic [AW-1:0] r, input logic [2:0] p);
		pos_get = r[p*arm_pkg::NBITS +: arm_pkg::NBITS];
	endfunction : pos_get

	arm_digit_mod u_mod (
		.m (mif.mdf)
	);

	// apb decode; no wait states
	assign wr      = psel && penable && pwrite;
	assign rd      = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;
	assign ctrl_wr = wr && (paddr == arm_pkg::OFS_CTRL);
	assign ser_wr  = wr && (paddr == arm_pkg::OFS_SERIAL) && (ser_reg < 3'(arm_pkg::NREGS));
	assign ser_reg = pwdata[arm_pkg::SER_REG_LSB +: 3];
	assign ser_bits = pwdata[arm_pkg::NBITS-1:0];
	// a new cycle is refused while one is running
	assign start   = ctrl_wr && pwdata[arm_pkg::CTRL_START] && (gate_ff == arm_pkg::G_IDLE);
	assign tgt     = arm_pkg::cyc_target(cyc_ff);
	assign storage_addr = star_ff;
	assign cycle_busy   = (gate_ff != arm_pkg::G_IDLE);

	// selected register gated in parallel onto the address bus
	always_comb
	begin
		addr_bus = '0;
		if (sel_ff < 3'(arm_pkg::NREGS))
			addr_bus = regs_ff[sel_ff];
	end

	// scan latches choose the starting modifier control
	always_comb
	begin
		case (scan_ff)
			arm_pkg::SCAN_FIRST:  preset_mode = arm_pkg::MOD_MINUS;
			arm_pkg::SCAN_THIRD:  preset_mode = arm_pkg::MOD_MINUS;
			arm_pkg::SCAN_SECOND: preset_mode = arm_pkg::MOD_PLUS;
			default:              preset_mode = arm_pkg::MOD_ZERO;
		endcase
	end

	// modifier is fed from the storage address, one position at a time
	assign mif.digit_in = pos_get(star_ff, mpos_ff);
	assign mif.mode_in  = mode_ff;

	// logic clock pulse divider: two pulses per gate
	assign tick = cycle_busy && (div_ff == arm_pkg::PULSE_LAST);
	assign p1   = tick && !phase_ff;
	assign p2   = tick && phase_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_ff <= 8'h00;
		else if (start || tick)
			div_ff <= 8'h00;
		else if (cycle_busy)
			div_ff <= 8'(div_ff + 8'h01);
	end

	// gate sequencer: A..F then idle, one storage cycle in all
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gate_ff  <= arm_pkg::G_IDLE;
			phase_ff <= 1'b0;
		end
		else if (start)
		begin
			gate_ff  <= arm_pkg::G_A;
			phase_ff <= 1'b0;
		end
		else if (p1)
			phase_ff <= 1'b1;
		else if (p2)
		begin
			phase_ff <= 1'b0;
			case (gate_ff)
				arm_pkg::G_A: gate_ff <= arm_pkg::G_B;
				arm_pkg::G_B: gate_ff <= arm_pkg::G_C;
				arm_pkg::G_C: gate_ff <= arm_pkg::G_D;
				arm_pkg::G_D: gate_ff <= arm_pkg::G_E;
				arm_pkg::G_E: gate_ff <= arm_pkg::G_F;
				default:      gate_ff <= arm_pkg::G_IDLE;
			endcase
		end
	end

	// modifier controls and position walked
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_ff <= arm_pkg::MOD_ZERO;
			mpos_ff <= arm_pkg::POS_UNITS;
		end
		else if (p1 && gate_ff == arm_pkg::G_B)
		begin
			mode_ff <= preset_mode;
			mpos_ff <= arm_pkg::POS_UNITS;
		end
		else if (p2 && gate_ff != arm_pkg::G_A && gate_ff != arm_pkg::G_IDLE)
		begin
			mode_ff <= mif.mode_out;
			if (mpos_ff != arm_pkg::POS_TTH)
				mpos_ff <= 3'(mpos_ff + 3'h1);
		end
	end

	// control fields written by software
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sel_ff  <= arm_pkg::R_I;
			cyc_ff  <= arm_pkg::CYC_I;
			scan_ff <= arm_pkg::SCAN_NONE;
		end
		else if (ctrl_wr && !cycle_busy)
		begin
			sel_ff  <= pwdata[arm_pkg::CTRL_SEL_LSB +: 3];
			cyc_ff  <= (pwdata[arm_pkg::CTRL_CYC_LSB +: 2] == 2'h3) ? arm_pkg::CYC_I
				: arm_pkg::arm_cycle_t'(pwdata[arm_pkg::CTRL_CYC_LSB +: 2]);
			scan_ff <= arm_pkg::arm_scan_t'(pwdata[arm_pkg::CTRL_SCAN_LSB +: 2]);
		end
	end

	// storage address register: no per-cycle reset, loads whole from the bus
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			star_ff <= '0;
		else if (ctrl_wr && pwdata[arm_pkg::CTRL_PROGRST] && !cycle_busy)
			star_ff <= '0;
		else if (p2 && gate_ff == arm_pkg::G_A)
			star_ff <= addr_bus;
	end

	// serial channel position pointer, restarts at ten-thousands on reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ser_pos_ff <= arm_pkg::POS_TTH;
		else if (ctrl_wr && pwdata[arm_pkg::CTRL_REGRST] && !cycle_busy)
			ser_pos_ff <= arm_pkg::POS_TTH;
		else if (ser_wr && !cycle_busy)
			ser_pos_ff <= (ser_pos_ff == arm_pkg::POS_UNITS) ? arm_pkg::POS_TTH
				: 3'(ser_pos_ff - 3'h1);
	end

	// working registers: A,B loaded from instruction fields; C,D,E,F from channel too
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int r = 0; r < arm_pkg::NREGS; r++)
				regs_ff[r] <= '0;
		end
		else if (cycle_busy)
		begin
			if (p1 && gate_ff == arm_pkg::G_B)
				regs_ff[tgt] <= '0;
			else if (p2 && gate_ff != arm_pkg::G_A)
				regs_ff[tgt][mpos_ff*arm_pkg::NBITS +: arm_pkg::NBITS]
					<= mif.digit_out;
		end
		else if (ctrl_wr && pwdata[arm_pkg::CTRL_REGRST])
			regs_ff[pwdata[arm_pkg::CTRL_SEL_LSB +: 3]] <= '0;
		else if (ctrl_wr && pwdata[arm_pkg::CTRL_EXEC])
		begin
			regs_ff[arm_pkg::R_C] <= regs_ff[arm_pkg::R_A];
			regs_ff[arm_pkg::R_D] <= regs_ff[arm_pkg::R_B];
		end
		else if (ctrl_wr && pwdata[arm_pkg::CTRL_IFROMSTAR])
			regs_ff[arm_pkg::R_I] <= star_ff;
		else if (ser_wr)
		begin
			// latch sets only where channel bit, position line and register line meet
			for (int b = 0; b < arm_pkg::NBITS; b++)
				if (ser_bits[b])
					regs_ff[ser_reg][ser_pos_ff*arm_pkg::NBITS + b] <= 1'b1;
		end
	end

	// read mux
	always_comb
	begin
		mapped = 1'b1;
		rd_val = '0;
		if (paddr == arm_pkg::OFS_CTRL)
			rd_val = {25'h0, scan_ff, cyc_ff, sel_ff};
		else if (paddr == arm_pkg::OFS_SERIAL)
			rd_val = {29'h0, ser_pos_ff};
		else if (paddr == arm_pkg::OFS_STAR)
			rd_val = {7'h0, star_ff};
		else if (paddr == arm_pkg::OFS_VIEW)
			rd_val = {7'h0, addr_bus};
		else if (paddr == arm_pkg::OFS_STATUS)
			rd_val = {21'h0, mpos_ff, 2'h0, mode_ff, gate_ff, cycle_busy};
		else
			mapped = 1'b0;
	end

	// data and error outputs come from flip-flops, valid in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata_ff  <= pwrite ? 32'h0000_0000 : rd_val;
			pslverr_ff <= !mapped;
		end
		else if (!psel)
			pslverr_ff <= 1'b0;
	end
endmodule : arm_unit

/* File: tb/arm_core_model.sv */
// core storage model: takes the address of each storage cycle, flags bad codes
`timescale 1ns/100ps
module arm_core_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [24:0] storage_addr,
	input  wire logic        cycle_busy,
	output logic      [24:0] fetch_addr,
	output logic             bad_code
);
	logic busy_q;
	// address taken as the cycle ends, long after it settled
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			busy_q     <= 1'b0;
			fetch_addr <= 25'h0;
			bad_code   <= 1'b0;
		end
		else
		begin
			busy_q <= cycle_busy;
			if (busy_q && !cycle_busy)
			begin
				fetch_addr <= storage_addr;
				bad_code   <= 1'b0;
				for (int p = 0; p < 5; p++)
					if ($countones(storage_addr[5*p +: 5]) != 2)
						bad_code <= 1'b1;
			end
		end
endmodule : arm_core_model

/* File: tb/arm_unit_assertions.sv */
// concurrent checks on the address register unit ports
`timescale 1ns/100ps
module arm_unit_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [24:0] storage_addr,
	input wire logic        cycle_busy
);
	logic [8:0] busy_cnt_ff;
	logic       ctl_wr;
	logic       start_req;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	assign ctl_wr = psel && penable && pwrite && paddr == arm_pkg::OFS_CTRL;
	assign start_req = ctl_wr && pwdata[arm_pkg::CTRL_START];
	// counts edges seen busy so a gate pulse can be named by its number
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			busy_cnt_ff <= 9'h000;
		else if (cycle_busy)
			busy_cnt_ff <= busy_cnt_ff + 9'h001;
		else
			busy_cnt_ff <= 9'h000;
	a_busy_cause: assert property ($rose(cycle_busy) |-> $past(start_req))
		else $error("cycle began without a start");
	a_start_busy: assert property (start_req && !cycle_busy |=> cycle_busy)
		else $error("start did not begin a cycle");
	a_cycle_len: assert property ($fell(cycle_busy) |-> busy_cnt_ff == 9'h0d8)
		else $error("cycle length wrong");
	a_busy_limit: assert property (cycle_busy |-> busy_cnt_ff < 9'h0e1)
		else $error("cycle longer than storage cycle");
	a_star_load: assert property (cycle_busy && $changed(storage_addr) |-> busy_cnt_ff == 9'h024)
		else $error("storage address loaded off gate A pulse two");
	a_star_hold: assert property (!cycle_busy && !(ctl_wr && pwdata[11]) |=> $stable(storage_addr))
		else $error("storage address changed while idle");
	a_prog_clear: assert property (ctl_wr && pwdata[11] && !cycle_busy |=> storage_addr == 25'h0)
		else $error("program reset did not clear storage address");
	a_star_read: assert property (psel && penable && !pwrite && paddr == arm_pkg::OFS_STAR
		|-> prdata == {7'h00, $past(storage_addr)})
		else $error("storage address read back wrong");
endmodule : arm_unit_assertions

/* File: tb/arm_unit_tb.sv */
// self-checking bench for the address register unit
`timescale 1ns/100ps
module arm_unit_tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [24:0] storage_addr;
	logic        cycle_busy;
	logic [24:0] fetch_addr;
	logic        bad_code;
	logic [32:0] exp_q[$];
	int          n_fail;
	int          checks;
	int          seed;
	int          star;
	int          val[7];
	arm_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .storage_addr(storage_addr), .cycle_busy(cycle_busy));
	arm_core_model core (.pclk(pclk), .presetn(presetn), .storage_addr(storage_addr),
		.cycle_busy(cycle_busy), .fetch_addr(fetch_addr), .bad_code(bad_code));
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic wrap_up;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic logic [24:0] enc(input int v);
		logic [4:0]  t[10] = '{5'h14, 5'h03, 5'h05, 5'h06, 5'h09, 5'h0a, 5'h0c, 5'h11, 5'h18, 5'h12};
		logic [24:0] r;
		for (int p = 0; p < 5; p++)
		begin
			r[5*p +: 5] = t[v % 10];
			v = v / 10;
		end
		return r;
	endfunction : enc
	// ends with one idle edge so a following setup never lands in the release step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			n_fail++;
			wrap_up();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic view(input int r);
		apb(1'b1, arm_pkg::OFS_CTRL, 32'(r));
		rd(arm_pkg::OFS_VIEW, {8'h00, enc(val[r])});
	endtask : view
	task automatic load(input int r, input int v);
		logic [24:0] e;
		e = enc(v);
		apb(1'b1, arm_pkg::OFS_CTRL, 32'(r));
		apb(1'b1, arm_pkg::OFS_CTRL, 32'h1000 | 32'(r));
		for (int p = 4; p >= 0; p--)
			apb(1'b1, arm_pkg::OFS_SERIAL, {21'h0, 3'(r), 3'h0, e[5*p +: 5]});
		val[r] = v;
		view(r);
	endtask : load
	task automatic run(input logic [1:0] c, input logic [1:0] sc);
		int         n;
		logic [2:0] t;
		t = (c == 2'h1) ? arm_pkg::R_A : (c == 2'h2) ? arm_pkg::R_B : arm_pkg::R_I;
		star = val[t];
		apb(1'b1, arm_pkg::OFS_CTRL, {23'h0, 2'h2, sc, c, t});
		n = 0;
		while (cycle_busy !== 1'b0 && n < 400)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 400)
		begin
			n_fail++;
			wrap_up();
		end
		val[t] = (sc == 2'h0) ? star : (sc == 2'h2) ? (star + 1) % 100000 : (star + 99999) % 100000;
		rd(arm_pkg::OFS_STAR, {8'h00, enc(star)});
		chk(fetch_addr, enc(star), "fetched");
		chk(bad_code, 1'b0, "code");
		view(t);
	endtask : run
	always @(posedge pclk)
		if (psel && penable && !pwrite && pready)
			chk({pslverr, prdata}, exp_q.pop_front(), "read");
	initial
	begin
		seed = 97284;
		n_fail = 0;
		checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(arm_pkg::OFS_STAR, 33'h0);
		rd(8'h40, 33'h100000000);
		for (int r = 0; r < 7; r++)
			load(r, $unsigned($random(seed)) % 100000);
		load(1, 4000);
		run(2'h1, 2'h1);
		load(2, 9999);
		run(2'h2, 2'h2);
		load(0, 0);
		run(2'h0, 2'h3);
		run(2'h3, 2'h0);
		for (int i = 0; i < 6; i++)
			run(2'($unsigned($random(seed)) % 3), 2'($unsigned($random(seed)) % 4));
		apb(1'b1, arm_pkg::OFS_CTRL, 32'h200);
		val[3] = val[1];
		val[4] = val[2];
		view(3);
		view(4);
		apb(1'b1, arm_pkg::OFS_CTRL, 32'h400);
		val[0] = star;
		view(0);
		apb(1'b1, arm_pkg::OFS_CTRL, 32'h800);
		rd(arm_pkg::OFS_STAR, 33'h0);
		wrap_up();
	end
endmodule : arm_unit_tb
bind arm_unit arm_unit_assertions chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .storage_addr(storage_addr), .cycle_busy(cycle_busy));
